// ### verilog/acr_regs.sv
// Summary of operation
// R01 - Bits 15-14 pick internal ref (00) or external 2.048/1.500/1.024 V.
// R02 - Software keeps ref select bits 13-0 by read-modify-write.
// R03 - Offset correction bits 8-0 hold a 9-bit two's complement trim.
// R04 - Offset correction bits 15-9 read as zero and ignore writes.
// R05 - Four slot channel map registers hold sixteen 4-bit slot fields.
// R06 - Slot values 0-7 pick group A inputs 0-7, 8-15 group B inputs 0-7.
// R07 - Cascaded, conversions nine to sixteen land in buffers 8 to 15.
// R08 - View 0x7108-0x7117 reads left-justified in 15-4, two wait states.
// R09 - View 0x0B00-0x0B0F reads results right-justified, no wait states.
// R10 - Right view bits 15-12 read zero; read-only, reset zero.
// R11 - Slot n feeds conversion n+1, whose result lands in buffer n; with seq2 alone, not cascaded, the code writes it to buffer n+8.
`timescale 1ns/100ps
module acr_regs (
   input  wire logic                          I_CLK,
   input  wire logic                          I_RSTN,
   // control frame
   input  wire logic                          I_CTL_SEL,
   input  wire logic                          I_CTL_WR,
   input  wire logic [acr_pkg::CTL_AW-1:0]    I_CTL_ADDR,
   input  wire logic [acr_pkg::DATA_W-1:0]    I_CTL_WDATA,
   output logic      [acr_pkg::DATA_W-1:0]    O_CTL_RDATA,
   // result frames
   input  wire logic                          I_RES_RD,
   input  wire logic [acr_pkg::MEM_AW-1:0]    I_RES_ADDR,
   output logic      [acr_pkg::DATA_W-1:0]    O_RES_RDATA,
   output logic                               O_RES_READY,
   // sequencer side
   input  wire logic                          I_CASCADED,
   input  wire logic                          I_SEQ2_ACTIVE,
   input  wire logic [acr_pkg::IDX_W-1:0]     I_CONV_INDEX,
   input  wire logic                          I_RESULT_VALID,
   input  wire logic [acr_pkg::RES_W-1:0]     I_RESULT_DATA,
   output logic      [acr_pkg::CH_W-1:0]      O_SEQUENCE_SLOT_CHANNEL,
   output logic                               O_INPUT_GROUP_B,
   output logic      [2:0]                    O_INPUT_INDEX,
   output logic      [1:0]                    O_REF_SEL,
   output logic                               O_EXTERNAL_REFERENCE_INPUT,
   output logic      [acr_pkg::OFFSET_W-1:0]  O_OFFSET_CORRECTION
);
   import acr_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [DATA_W-1:0]      slot_map_reg [4];
   logic [DATA_W-1:0]      ref_sel_reg;
   logic [OFFSET_W-1:0]    offset_reg;
   logic [CH_W-1:0]        slot_chan_reg;
   logic [1:0]             wait_cnt_reg;
   logic [1:0]             wait_cnt_next;
   logic                   left_reg;
   logic                   busy_reg;

   function automatic logic [CH_W-1:0] slot_field(
      input logic [DATA_W-1:0] word,
      input logic [1:0]        nib
   );
      slot_field = word[nib*CH_W +: CH_W];
   endfunction

   // ----------------------------------------
   // control decode and writes
   // ----------------------------------------
   wire ctl_wr = I_CTL_SEL && I_CTL_WR;
   wire hit_map = I_CTL_ADDR >= OFS_SLOT_MAP_0 && I_CTL_ADDR <= OFS_SLOT_MAP_3;
   wire [1:0] map_idx = 2'(I_CTL_ADDR - OFS_SLOT_MAP_0);
   wire hit_ref = I_CTL_ADDR == OFS_REF_SEL;
   wire hit_off = I_CTL_ADDR == OFS_OFFSET_CORR;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_map
         always_ff @(posedge I_CLK or negedge I_RSTN) begin
            if (!I_RSTN) begin
               slot_map_reg[g] <= RESET_VALUE;
            end else if (ctl_wr && hit_map && map_idx == 2'(g)) begin
               slot_map_reg[g] <= I_CTL_WDATA; // R05
            end
         end
      end
   endgenerate

   // full word stored: calibration bits are software's to keep
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ref_sel_reg <= RESET_VALUE;
      end else if (ctl_wr && hit_ref) begin
         ref_sel_reg <= I_CTL_WDATA; // R02
      end
   end

   // bits 15-9 dropped on write
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         offset_reg <= RESET_VALUE[OFFSET_W-1:0];
      end else if (ctl_wr && hit_off) begin
         offset_reg <= I_CTL_WDATA[OFFSET_W-1:0]; // R03 R04
      end
   end

   // unmapped control reads return zero
   wire [DATA_W-1:0] ctl_rd =
      hit_map ? slot_map_reg[map_idx] :
      hit_ref ? ref_sel_reg :
      hit_off ? {{(DATA_W-OFFSET_W){1'b0}}, offset_reg} : // R04
      RESET_VALUE;

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_CTL_RDATA <= RESET_VALUE;
      end else begin
         O_CTL_RDATA <= ctl_rd;
      end
   end

   // ----------------------------------------
   // reference and trim outputs
   // ----------------------------------------
   wire [1:0] ref_field = ref_sel_reg[REF_SEL_LSB +: 2];
   assign O_REF_SEL = ref_field; // R01
   assign O_EXTERNAL_REFERENCE_INPUT =
      acr_ref_t'(ref_field) != ACR_REF_INTERNAL; // R01
   assign O_OFFSET_CORRECTION = offset_reg; // R03

   // ----------------------------------------
   // slot to channel selection
   // ----------------------------------------
   wire [IDX_W-1:0] slot_idx = I_CONV_INDEX; // R11
   wire [CH_W-1:0] slot_val =
      slot_field(slot_map_reg[slot_idx[3:2]], slot_idx[1:0]); // R05 R11

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         slot_chan_reg <= RESET_VALUE[CH_W-1:0];
      end else begin
         slot_chan_reg <= slot_val;
      end
   end

   assign O_SEQUENCE_SLOT_CHANNEL = slot_chan_reg;
   assign O_INPUT_GROUP_B = |(slot_chan_reg & GROUP_B_BIT); // R06
   assign O_INPUT_INDEX = slot_chan_reg[2:0]; // R06

   // ----------------------------------------
   // result buffer write
   // ----------------------------------------
   // seq2 alone writes the upper half; cascade counts straight through
   wire [IDX_W-1:0] wr_idx =
      (I_CASCADED || !I_SEQ2_ACTIVE) ? I_CONV_INDEX :
      {1'b1, I_CONV_INDEX[2:0]}; // R07 R11

   logic [RES_W-1:0] mem_rdata;

   acr_result_mem u_mem (
      .i_clk   (I_CLK),
      .i_rstn  (I_RSTN),
      .i_we    (I_RESULT_VALID),
      .i_waddr (wr_idx),
      .i_wdata (I_RESULT_DATA),
      .i_raddr (I_RES_ADDR[IDX_W-1:0]),
      .o_rdata (mem_rdata)
   );

   // ----------------------------------------
   // result read views
   // ----------------------------------------
   wire hit_left = I_RES_ADDR >= LEFT_VIEW_BASE &&
                   I_RES_ADDR <= LEFT_VIEW_LAST;
   wire hit_right = I_RES_ADDR >= RIGHT_VIEW_BASE &&
                    I_RES_ADDR <= RIGHT_VIEW_LAST;
   wire start = I_RES_RD && !busy_reg;

   // base 0x7108 has low nibble 8: index wraps modulo 16 as wanted
   always_comb begin
      wait_cnt_next = wait_cnt_reg;
      if (start) begin
         wait_cnt_next = hit_left ? LEFT_VIEW_WAITS
                                  : RIGHT_VIEW_WAITS; // R08 R09
      end else if (busy_reg && wait_cnt_reg != 2'h0) begin
         wait_cnt_next = wait_cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         wait_cnt_reg <= 2'h0;
         busy_reg     <= 1'b0;
         left_reg     <= 1'b0;
      end else begin
         wait_cnt_reg <= wait_cnt_next;
         busy_reg     <= start ? 1'b1 :
                         (wait_cnt_reg == 2'h0 ? 1'b0 : busy_reg);
         left_reg     <= start ? hit_left : left_reg;
      end
   end

   // unmapped result addresses answer zero
   logic hit_any_reg;
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         hit_any_reg <= 1'b0;
      end else if (start) begin
         hit_any_reg <= hit_left || hit_right;
      end
   end

   // ----------------------------------------
   // result read data
   // ----------------------------------------
   wire [DATA_W-1:0] left_word =
      {mem_rdata, {LEFT_PAD_W{1'b0}}}; // R08
   wire [DATA_W-1:0] right_word =
      {{(DATA_W-RES_W){1'b0}}, mem_rdata}; // R09 R10
   wire ready_now = busy_reg && wait_cnt_reg == 2'h0;

   assign O_RES_READY = ready_now;
   assign O_RES_RDATA = !hit_any_reg ? RESET_VALUE :
      left_reg ? left_word : right_word;
endmodule

// ### pkg/acr_pkg.sv
package acr_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int unsigned DATA_W    = 16;
   localparam int unsigned RES_W     = 12;
   localparam int unsigned CH_W      = 4;
   localparam int unsigned SLOT_N    = 16;
   localparam int unsigned IDX_W     = 4;
   localparam int unsigned CTL_AW    = 5;
   localparam int unsigned MEM_AW    = 16;

   // ----------------------------------------
   // control frame register offsets (word index)
   // ----------------------------------------
   localparam logic [CTL_AW-1:0] OFS_SLOT_MAP_0   = 5'h03;
   localparam logic [CTL_AW-1:0] OFS_SLOT_MAP_1   = 5'h04;
   localparam logic [CTL_AW-1:0] OFS_SLOT_MAP_2   = 5'h05;
   localparam logic [CTL_AW-1:0] OFS_SLOT_MAP_3   = 5'h06;
   localparam logic [CTL_AW-1:0] OFS_REF_SEL      = 5'h1c;
   localparam logic [CTL_AW-1:0] OFS_OFFSET_CORR  = 5'h1d;

   // ----------------------------------------
   // result views (absolute addresses)
   // ----------------------------------------
   localparam logic [MEM_AW-1:0] LEFT_VIEW_BASE   = 16'h7108;
   localparam logic [MEM_AW-1:0] LEFT_VIEW_LAST   = 16'h7117;
   localparam logic [MEM_AW-1:0] RIGHT_VIEW_BASE  = 16'h0b00;
   localparam logic [MEM_AW-1:0] RIGHT_VIEW_LAST  = 16'h0b0f;
   localparam logic [1:0]        LEFT_VIEW_WAITS  = 2'h2;
   localparam logic [1:0]        RIGHT_VIEW_WAITS = 2'h0;

   // ----------------------------------------
   // field layout and reset values
   // ----------------------------------------
   localparam int unsigned REF_SEL_LSB   = 14;
   localparam int unsigned REF_CAL_W     = 14;
   localparam int unsigned OFFSET_W      = 9;
   localparam int unsigned LEFT_PAD_W    = 4;
   localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
   localparam logic [CH_W-1:0]   GROUP_B_BIT = 4'h8;

   typedef enum logic [1:0] {
      ACR_REF_INTERNAL,
      ACR_REF_EXT_2V048,
      ACR_REF_EXT_1V500,
      ACR_REF_EXT_1V024
   } acr_ref_t;
endpackage

// ### verilog/acr_result_mem.sv
`timescale 1ns/100ps
module acr_result_mem (
   input  wire logic                            i_clk,
   input  wire logic                            i_rstn,
   input  wire logic                            i_we,
   input  wire logic [acr_pkg::IDX_W-1:0]       i_waddr,
   input  wire logic [acr_pkg::RES_W-1:0]       i_wdata,
   input  wire logic [acr_pkg::IDX_W-1:0]       i_raddr,
   output logic      [acr_pkg::RES_W-1:0]       o_rdata
);
   import acr_pkg::*;

   logic [RES_W-1:0] mem_reg [SLOT_N];

   genvar g;
   generate
      for (g = 0; g < SLOT_N; g++) begin : g_word
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               mem_reg[g] <= RESET_VALUE[RES_W-1:0];
            end else if (i_we && i_waddr == IDX_W'(g)) begin
               mem_reg[g] <= i_wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= RESET_VALUE[RES_W-1:0];
      end else begin
         o_rdata <= mem_reg[i_raddr];
      end
   end
endmodule

// ### test/acr_regs_props.sv
`timescale 1ns/100ps
module acr_regs_props
   import acr_pkg::*;
(
   input wire logic                I_CLK,
   input wire logic                I_RSTN,
   input wire logic                I_CTL_SEL,
   input wire logic                I_CTL_WR,
   input wire logic [CTL_AW-1:0]   I_CTL_ADDR,
   input wire logic [DATA_W-1:0]   I_CTL_WDATA,
   input wire logic [DATA_W-1:0]   O_CTL_RDATA,
   input wire logic                I_RES_RD,
   input wire logic [MEM_AW-1:0]   I_RES_ADDR,
   input wire logic [DATA_W-1:0]   O_RES_RDATA,
   input wire logic                O_RES_READY,
   input wire logic [CH_W-1:0]     O_SEQUENCE_SLOT_CHANNEL,
   input wire logic                O_INPUT_GROUP_B,
   input wire logic [2:0]          O_INPUT_INDEX,
   input wire logic [1:0]          O_REF_SEL,
   input wire logic                O_EXTERNAL_REFERENCE_INPUT,
   input wire logic [OFFSET_W-1:0] O_OFFSET_CORRECTION
);
   // ---------------------------------------------
   // result access tracker
   // ---------------------------------------------
   logic [1:0] cnt_reg;
   wire        taken = I_RES_RD && cnt_reg == 2'h0;
   wire        left  = I_RES_ADDR >= LEFT_VIEW_BASE
                       && I_RES_ADDR <= LEFT_VIEW_LAST;
   wire        right = I_RES_ADDR >= RIGHT_VIEW_BASE
                       && I_RES_ADDR <= RIGHT_VIEW_LAST;
   wire        ctl_wr = I_CTL_SEL && I_CTL_WR;
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN)
         cnt_reg <= 2'h0;
      else if (taken)
         cnt_reg <= left ? 2'h3 : 2'h1;
      else if (cnt_reg != 2'h0)
         cnt_reg <= cnt_reg - 2'h1;
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   chk_ready_timing: assert property (O_RES_READY == (cnt_reg == 2'h1))
      else $error("result ready out of step");
   chk_left_waits: assert property (taken && left |->
      ##1 (!O_RES_READY) [*2] ##1 O_RES_READY)
      else $error("left view wait states wrong");
   chk_right_zero: assert property (taken && right |=> O_RES_READY)
      else $error("right view answer late");
   chk_left_pad: assert property (O_RES_READY && left |->
      O_RES_RDATA[3:0] == 4'h0) else $error("left view low bits set");
   chk_right_pad: assert property (O_RES_READY && right |->
      O_RES_RDATA[15:12] == 4'h0) else $error("right view high bits set");
   chk_offset_pad: assert property (
      $past(I_CTL_SEL && I_CTL_ADDR == OFS_OFFSET_CORR)
      |-> O_CTL_RDATA[15:9] == 7'h00) else $error("offset pad bits set");
   chk_offset_store: assert property (
      ctl_wr && I_CTL_ADDR == OFS_OFFSET_CORR
      |=> O_OFFSET_CORRECTION == $past(I_CTL_WDATA[8:0]))
      else $error("offset trim not stored");
   chk_ref_store: assert property (ctl_wr && I_CTL_ADDR == OFS_REF_SEL
      |=> O_REF_SEL == $past(I_CTL_WDATA[15:14]))
      else $error("reference code not stored");
   chk_ref_flag: assert property (
      O_EXTERNAL_REFERENCE_INPUT == (O_REF_SEL != 2'h0))
      else $error("external reference flag wrong");
   chk_slot_decode: assert property (
      {O_INPUT_GROUP_B, O_INPUT_INDEX} == O_SEQUENCE_SLOT_CHANNEL)
      else $error("slot decode wrong");
   cover property (taken && left);
   cover property (taken && right);
   cover property (ctl_wr && I_CTL_ADDR == OFS_REF_SEL);
endmodule
bind acr_regs acr_regs_props u_props (.*);

// ### test/adc_config_result_regs_test.sv
`timescale 1ns/100ps
module adc_config_result_regs_test;
   import acr_pkg::*;
   logic              clk = 1'b0, rstn = 1'b0, sel = 1'b0, wr = 1'b0;
   logic              rd = 1'b0, casc = 1'b1, seq2 = 1'b0, valid = 1'b0;
   logic [CTL_AW-1:0] caddr = '0;
   logic [15:0]       wdata = '0, raddr = '0, cdata, rdata;
   logic [3:0]        cidx = '0, slot_ch;
   logic [11:0]       rres = '0;
   logic              ready, grp_b, ext;
   logic [2:0]        in_idx;
   logic [1:0]        ref_sel;
   logic [8:0]        ofs;
   logic [15:0]       regs_m [0:31] = '{default: '0};
   logic [11:0]       res_m [0:15] = '{default: '0};
   logic [4:0]        tbl [0:7] = '{5'h03, 5'h04, 5'h05, 5'h06,
                                    5'h1c, 5'h1d, 5'h00, 5'h1f};
   int                err_total = 0, comparisons = 0, i, seed = 32'h1ce3;
   always #4 clk = ~clk;
   acr_regs dut (.I_CLK(clk), .I_RSTN(rstn), .I_CTL_SEL(sel),
      .I_CTL_WR(wr), .I_CTL_ADDR(caddr), .I_CTL_WDATA(wdata),
      .O_CTL_RDATA(cdata), .I_RES_RD(rd), .I_RES_ADDR(raddr),
      .O_RES_RDATA(rdata), .O_RES_READY(ready), .I_CASCADED(casc),
      .I_SEQ2_ACTIVE(seq2), .I_CONV_INDEX(cidx), .I_RESULT_VALID(valid),
      .I_RESULT_DATA(rres), .O_SEQUENCE_SLOT_CHANNEL(slot_ch),
      .O_INPUT_GROUP_B(grp_b), .O_INPUT_INDEX(in_idx), .O_REF_SEL(ref_sel),
      .O_EXTERNAL_REFERENCE_INPUT(ext), .O_OFFSET_CORRECTION(ofs));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic ctl_wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk);
      {sel, wr, caddr, wdata} = {2'b11, a, d};
      @(negedge clk);
      {sel, wr} = 2'b00;
      if (a inside {[5'h03:5'h06], OFS_REF_SEL})
         regs_m[a] = d;
      if (a == OFS_OFFSET_CORR)
         regs_m[a] = d & 16'h01ff;
      chk({7'h0, ofs}, regs_m[OFS_OFFSET_CORR]);
   endtask
   task automatic ctl_rd(input logic [4:0] a);
      @(negedge clk);
      {sel, wr, caddr} = {2'b10, a};
      @(negedge clk);
      sel = 1'b0;
      chk(cdata, regs_m[a]);
   endtask
   task automatic res_rd(input logic [15:0] a, e, input int w);
      int n = 0;
      @(negedge clk);
      {rd, raddr} = {1'b1, a};
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (ready !== 1'b1 && n < 8);
      chk(16'(n), 16'(w + 1));
      chk(rdata, e);
      @(posedge clk);
      @(negedge clk);
      rd = 1'b0;
      if (n == 8)
         wrap_up();
   endtask
   task automatic put_res(input logic [3:0] x, input logic [11:0] d);
      logic [15:0] s;
      @(negedge clk);
      {valid, cidx, rres} = {1'b1, x, d};
      @(negedge clk);
      valid = 1'b0;
      res_m[(casc || !seq2) ? x : {1'b1, x[2:0]}] = d;
      s = (regs_m[5'h03 + x[3:2]] >> {x[1:0], 2'b00}) & 16'h000f;
      chk({12'h0, slot_ch}, s);
      chk({12'h0, grp_b, in_idx}, s);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      for (i = 0; i < 8; i++) ctl_rd(tbl[i]);
      res_rd(16'h0b0f, 16'h0000, 0);
      for (i = 0; i < 8; i++) ctl_wr(tbl[i], 16'($random(seed)));
      for (i = 0; i < 8; i++) ctl_rd(tbl[i]);
      for (i = 0; i < 4; i++) begin
         ctl_wr(OFS_REF_SEL, {2'(i), regs_m[OFS_REF_SEL][13:0]});
         chk({14'h0, ref_sel}, 16'(i));
         chk({15'h0, ext}, {15'h0, i != 0});
         ctl_rd(OFS_REF_SEL);
      end
      ctl_wr(OFS_OFFSET_CORR, 16'hff00);
      ctl_wr(OFS_OFFSET_CORR, 16'hfeff);
      ctl_rd(OFS_OFFSET_CORR);
      ctl_wr(OFS_SLOT_MAP_0, 16'h3210);
      ctl_wr(OFS_SLOT_MAP_1, 16'h7654);
      ctl_wr(OFS_SLOT_MAP_2, 16'hba98);
      ctl_wr(OFS_SLOT_MAP_3, 16'hfedc);
      for (i = 0; i < 16; i++) put_res(4'(i), 12'($random(seed)));
      {casc, seq2} = 2'b01;
      for (i = 0; i < 8; i++) put_res(4'(i), 12'($random(seed)));
      {casc, seq2} = 2'b00;
      put_res(4'h2, 12'($random(seed)));
      for (i = 0; i < 16; i++) begin
         res_rd(16'h0b00 + 16'(i), {4'h0, res_m[i]}, 0);
         res_rd(i < 8 ? 16'h7110 + 16'(i) : 16'h7100 + 16'(i),
                {res_m[i], 4'h0}, 2);
      end
      res_rd(16'h0c00, 16'h0000, 0);
      wrap_up();
   end
endmodule
